// ===== common/rss_pkg.sv
// reset source sequencer package: state codes, timing and fetch addresses
// assumes nothing beyond a synthesizable sv toolchain
package rss_pkg;
    localparam int CLK_MHZ = 125;
    localparam int CLK_PER_INST = 4;          // instruction cycle is four main clocks
    localparam int SHORT_RESET_INST = 4;      // internal reset length in instruction cycles
    localparam int SHORT_RESET_CYC = SHORT_RESET_INST * CLK_PER_INST;
    localparam int TBT_WIDTH = 18;            // timebase timer width
    localparam int TBT_SEL_BIT = 17;          // overflow bit ending the stabilization wait
    localparam logic [15:0] MODE_ADDR = 16'hFFFD;
    localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
    localparam logic [7:0] MODE_SINGLE_CHIP = 8'h00;

    typedef enum logic [6:0]
    {
        RSS_POR_WAIT = 7'h01, // power-on stabilization reset
        RSS_STAB = 7'h02,     // stabilization reset from stop mode
        RSS_PIN_HOLD = 7'h04, // held by the pin
        RSS_SHORT = 7'h08,    // four-instruction internal reset
        RSS_FETCH_MODE = 7'h10,
        RSS_FETCH_VEC = 7'h20,
        RSS_RUN = 7'h40
    } rss_state_type;
endpackage : rss_pkg

// ===== rtl/rss_fetch.sv
// mode fetch unit: reads mode byte, then vector high and low, then issues the start address
// assumes rom data returns one cycle after the address is presented
`timescale 1ns/1ps
module rss_fetch
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [7:0] rom_data,
    output logic [15:0] rom_addr,
    output logic rom_rd,
    output logic [7:0] mode_byte,
    output logic [15:0] start_pc,
    output logic mode_read,
    output logic done
);
    typedef struct packed
    {
        logic [2:0] step;
        logic [15:0] addr;
        logic rd;
        logic [7:0] mode;
        logic [15:0] pc;
        logic mode_read;
        logic done;
    } rss_fch_type;
    rss_fch_type st;
    rss_fch_type next_st;

    // step 1 mode, 2 vector high, 3 vector low, 4 capture low
    always_comb
    begin
        next_st = st;
        next_st.rd = 1'b0;
        if (start)
        begin
            next_st = '0;
            next_st.step = 3'h1;
            next_st.addr = rss_pkg::MODE_ADDR;
            next_st.rd = 1'b1;
        end
        else
        begin
            unique case (st.step)
                3'h1:
                begin
                    next_st.step = 3'h2;
                    next_st.addr = rss_pkg::VEC_HI_ADDR;
                    next_st.rd = 1'b1;
                end
                3'h2:
                begin
                    next_st.mode = rom_data;
                    next_st.mode_read = 1'b1;
                    next_st.step = 3'h3;
                    next_st.addr = rss_pkg::VEC_LO_ADDR;
                    next_st.rd = 1'b1;
                end
                3'h3:
                begin
                    next_st.pc[15:8] = rom_data;
                    next_st.step = 3'h4;
                end
                3'h4:
                begin
                    next_st.pc[7:0] = rom_data;
                    next_st.step = 3'h0;
                    next_st.done = 1'b1;
                end
                default:
                    next_st.step = 3'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign rom_addr = st.addr;
    assign rom_rd = st.rd;
    assign mode_byte = st.mode;
    assign start_pc = st.pc;
    assign mode_read = st.mode_read;
    assign done = st.done;
endmodule : rss_fetch

// ===== rtl/rss_reset_sequencer.sv
// reset source sequencer: merges pin, software, watchdog and power-on resets,
// inserts the stabilization wait, drives the reset pin low and runs the mode fetch
// assumes pin and request inputs are synchronous to clk and clk runs during reset
// How it works
// - low pin holds external reset; high pin releases the cpu
// - software reset bit written zero gives a four-instruction reset, no wait
// - watchdog overflow gives a four-instruction reset, no wait
// - with power-on option, power-up waits the stabilization delay before sequencing
// - without power-on option, no stabilization delay; reset held while pin low
// - pin reset in stop mode waits delay, then waits for pin release
// - pin reset while clock runs starts sequence at release, no delay
// - every reset ends in run mode; stopped-clock reset enters stabilization state
// - reset-output option drives pin low during delay and short resets
// - pin reset accepted asynchronously; completion still needs clock edges
// - fetch mode byte, then vector high and low, start at vector
// - stabilization delay is timed by the timebase timer
// - ram kept across non-power-on resets; write at pin reset may corrupt
// - i/o pins go high impedance while the mode byte is read
// - i/o pins stay high impedance until software reconfigures them
// - delay counts up from a cleared timer and ends at selected overflow bit
`timescale 1ns/1ps
module rss_reset_sequencer #(
    parameter bit HAS_POR = 1'b1,
    parameter bit HAS_RST_OUT = 1'b1,
    parameter int TBT_WIDTH = rss_pkg::TBT_WIDTH,
    parameter int TBT_SEL_BIT = rss_pkg::TBT_SEL_BIT
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rst_pin_n_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    input wire logic soft_reset_write,
    input wire logic soft_reset_bit,
    input wire logic watchdog_overflow,
    input wire logic stop_mode,
    input wire logic io_config_write,
    input wire logic [7:0] rom_data,
    output logic [15:0] rom_addr,
    output logic rom_rd,
    output logic internal_reset,
    output logic cpu_run,
    output logic [15:0] start_pc,
    output logic [7:0] mode_byte,
    output logic io_hiz,
    output logic ram_clear_req,
    output logic ram_write_block
);
    typedef struct packed
    {
        rss_pkg::rss_state_type state;
        logic [4:0] short_cnt;
        logic io_hiz;
        logic ram_clear;
        logic drive_low;
    } rss_top_type;
    rss_top_type st;
    rss_top_type next_st;

    logic pin_low;
    logic soft_req;
    logic tmr_clear;
    logic tmr_done;
    logic fetch_start;
    logic fetch_done;
    logic fetch_mode_read;

    // pin taken asynchronously
    // the pin reaches the sequencer combinationally so a low level acts even between edges;
    // our own pull-down is masked, else a short reset would turn itself into a pin reset
    // limitation: an outside pull that overlaps our own drive is seen only once ours ends
    assign pin_low = !rst_pin_n_in && !st.drive_low;
    assign soft_req = soft_reset_write && !soft_reset_bit;

    rss_stab_timer #(
        .WIDTH(TBT_WIDTH),
        .SEL_BIT(TBT_SEL_BIT)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(tmr_clear),
        .done(tmr_done)
    );

    rss_fetch u_fetch (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(fetch_start),
        .rom_data(rom_data),
        .rom_addr(rom_addr),
        .rom_rd(rom_rd),
        .mode_byte(mode_byte),
        .start_pc(start_pc),
        .mode_read(fetch_mode_read),
        .done(fetch_done)
    );

    // sequencing of the reset sources, priority: pin, watchdog, software
    always_comb
    begin
        next_st = st;
        tmr_clear = 1'b0;
        fetch_start = 1'b0;
        unique case (st.state)
            rss_pkg::RSS_POR_WAIT:
            begin
                if (!HAS_POR)
                    next_st.state = pin_low ? rss_pkg::RSS_PIN_HOLD : rss_pkg::RSS_FETCH_MODE;
                // wait release after delay
                // our own pull must end first, else the masked pin would hide an outside hold
                else if (tmr_done && !st.drive_low && !pin_low)
                    next_st.state = rss_pkg::RSS_FETCH_MODE;
            end
            rss_pkg::RSS_STAB:
            begin
                // same release wait after the stop-mode delay
                if (tmr_done && !st.drive_low && !pin_low)
                    next_st.state = rss_pkg::RSS_FETCH_MODE;
            end
            rss_pkg::RSS_PIN_HOLD:
            begin
                if (!pin_low)
                    next_st.state = rss_pkg::RSS_FETCH_MODE;
            end
            rss_pkg::RSS_SHORT:
            begin
                next_st.short_cnt = st.short_cnt - 1'b1;
                if (st.short_cnt == 5'h01)
                    next_st.state = rss_pkg::RSS_FETCH_MODE;
            end
            rss_pkg::RSS_FETCH_MODE:
            begin
                fetch_start = 1'b1;
                next_st.state = rss_pkg::RSS_FETCH_VEC;
            end
            rss_pkg::RSS_FETCH_VEC:
            begin
                if (fetch_done)
                begin
                    next_st.state = rss_pkg::RSS_RUN;
                    next_st.ram_clear = 1'b0;
                end
            end
            rss_pkg::RSS_RUN:
            begin
                next_st.state = rss_pkg::RSS_RUN;
            end
        endcase
        // a low pin overrides every state but the two delay states; watchdog and software act only in run
        if (pin_low && st.state != rss_pkg::RSS_POR_WAIT && st.state != rss_pkg::RSS_STAB)
        begin
            if (HAS_POR && stop_mode && st.state == rss_pkg::RSS_RUN)
            begin
                next_st.state = rss_pkg::RSS_STAB;
                tmr_clear = 1'b1;
            end
            else
                next_st.state = rss_pkg::RSS_PIN_HOLD;
        end
        else if ((watchdog_overflow || soft_req) && st.state == rss_pkg::RSS_RUN)
        begin
            next_st.state = rss_pkg::RSS_SHORT;
            next_st.short_cnt = 5'(rss_pkg::SHORT_RESET_CYC);
        end
        if (next_st.state != rss_pkg::RSS_RUN)
            next_st.io_hiz = 1'b1;
        else if (io_config_write)
            next_st.io_hiz = 1'b0;
        next_st.drive_low = HAS_RST_OUT && (next_st.state == rss_pkg::RSS_SHORT
            || ((next_st.state == rss_pkg::RSS_POR_WAIT || next_st.state == rss_pkg::RSS_STAB)
            && !tmr_done));
    end

    // timer cleared at power-on
    // the timer also leaves reset cleared, so power-on counting starts at zero
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st.state <= rss_pkg::RSS_POR_WAIT;
            st.short_cnt <= '0;
            st.io_hiz <= 1'b1;
            st.ram_clear <= 1'b1;
            st.drive_low <= 1'b0;
        end
        else
            st <= next_st;
    end

    assign internal_reset = (st.state != rss_pkg::RSS_RUN) || pin_low;
    assign cpu_run = !internal_reset;
    assign rst_pin_out = 1'b0;            // open drain, only ever pulls low
    assign rst_pin_oe = st.drive_low;
    assign io_hiz = st.io_hiz;
    // ram preserve
    // only power-on asks ram clear; writes are blocked while the pin is low and our own pull-down is off
    assign ram_clear_req = st.ram_clear && HAS_POR;
    assign ram_write_block = pin_low;

    AST_SHORT_DRIVES_PIN: assert property (@(posedge clk) disable iff (sys_rst)
        (st.state == rss_pkg::RSS_SHORT) |-> (rst_pin_oe == HAS_RST_OUT))
        else $error("pin not driven in short reset");
    AST_SOFT_SHORT: assert property (@(posedge clk) disable iff (sys_rst)
        (st.state == rss_pkg::RSS_RUN && soft_req && !pin_low && !watchdog_overflow)
        |=> (st.state == rss_pkg::RSS_SHORT)[*8] ##1 (st.state == rss_pkg::RSS_SHORT)[*8]
        ##1 (st.state == rss_pkg::RSS_FETCH_MODE))
        else $error("software reset length wrong");
    AST_WDT_SHORT: assert property (@(posedge clk) disable iff (sys_rst)
        (st.state == rss_pkg::RSS_RUN && watchdog_overflow && !pin_low)
        |=> st.state == rss_pkg::RSS_SHORT)
        else $error("watchdog reset not taken");
    AST_PIN_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
        !rst_pin_n_in |-> internal_reset)
        else $error("cpu released while pin low");
    AST_RUN_PIN_NO_DELAY: assert property (@(posedge clk) disable iff (sys_rst)
        (st.state == rss_pkg::RSS_RUN && pin_low && !stop_mode)
        |=> st.state == rss_pkg::RSS_PIN_HOLD)
        else $error("pin reset in run took a delay");
    AST_STAB_WAITS_PIN: assert property (@(posedge clk) disable iff (sys_rst)
        (st.state == rss_pkg::RSS_STAB && pin_low) |=> st.state == rss_pkg::RSS_STAB)
        else $error("stabilization left while pin low");
    AST_FETCH_ORDER: assert property (@(posedge clk) disable iff (sys_rst)
        (rom_rd && rom_addr == rss_pkg::MODE_ADDR)
        |=> (rom_rd && rom_addr == rss_pkg::VEC_HI_ADDR)
        ##1 (rom_rd && rom_addr == rss_pkg::VEC_LO_ADDR))
        else $error("fetch order wrong");
    AST_IO_HIZ_IN_RESET: assert property (@(posedge clk) disable iff (sys_rst)
        (st.state != rss_pkg::RSS_RUN && !$past(st.state == rss_pkg::RSS_RUN)) |-> io_hiz)
        else $error("io not floating in reset");
    AST_RUN_ONLY_IDLE_FREE: assert property (@(posedge clk) disable iff (sys_rst)
        cpu_run |-> st.state == rss_pkg::RSS_RUN && !pin_low)
        else $error("cpu running during reset");

    AST_POR_DRIVES_PIN: assert property (@(posedge clk) disable iff (sys_rst)
        (HAS_POR && st.state == rss_pkg::RSS_POR_WAIT && !tmr_done)
        |=> (rst_pin_oe == HAS_RST_OUT))
        else $error("pin not driven in power-on delay");

    AST_SHORT_NO_WAIT: assert property (@(posedge clk) disable iff (sys_rst)
        (st.state == rss_pkg::RSS_SHORT)
        |=> (st.state != rss_pkg::RSS_STAB && st.state != rss_pkg::RSS_POR_WAIT))
        else $error("short reset took a stabilization wait");

    AST_STOP_PIN_STAB: assert property (@(posedge clk) disable iff (sys_rst)
        (HAS_POR && st.state == rss_pkg::RSS_RUN && pin_low && stop_mode)
        |=> (st.state == rss_pkg::RSS_STAB && !tmr_done))
        else $error("stop-mode pin reset skipped the delay");

    AST_IO_HIZ_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
        (io_hiz && !io_config_write) |=> io_hiz)
        else $error("io left floating state without reconfiguration");

    AST_RAM_CLEAR_POR_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
        (st.state == rss_pkg::RSS_RUN) |-> !ram_clear_req)
        else $error("ram clear asked after power-on");

    // main paths the bench is expected to reach
    COV_SOFT: cover property (@(posedge clk) disable iff (sys_rst)
        st.state == rss_pkg::RSS_SHORT ##1 st.state == rss_pkg::RSS_FETCH_MODE);
    COV_STAB: cover property (@(posedge clk) disable iff (sys_rst)
        st.state == rss_pkg::RSS_STAB ##1 st.state == rss_pkg::RSS_FETCH_MODE);
    COV_RUN: cover property (@(posedge clk) disable iff (sys_rst)
        st.state == rss_pkg::RSS_FETCH_VEC ##1 st.state == rss_pkg::RSS_RUN);
    COV_PIN: cover property (@(posedge clk) disable iff (sys_rst)
        st.state == rss_pkg::RSS_PIN_HOLD ##1 st.state == rss_pkg::RSS_FETCH_MODE);
    COV_STAB_LATE_PIN: cover property (@(posedge clk) disable iff (sys_rst)
        st.state == rss_pkg::RSS_STAB && tmr_done && pin_low);
endmodule : rss_reset_sequencer

// ===== rtl/rss_stab_timer.sv
// stabilization timer: a cleared timebase counter that flags overflow at a chosen bit
// assumes the main clock keeps toggling while it counts
`timescale 1ns/1ps
module rss_stab_timer #(
    parameter int WIDTH = rss_pkg::TBT_WIDTH,
    parameter int SEL_BIT = rss_pkg::TBT_SEL_BIT
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clear,
    output logic done
);
    typedef struct packed
    {
        logic [WIDTH-1:0] count;
        logic done;
    } rss_tmr_type;
    rss_tmr_type st;
    rss_tmr_type next_st;

    // count from cleared state, stop once the selected bit sets
    always_comb
    begin
        next_st = st;
        if (clear)
        begin
            next_st.count = '0;
            next_st.done = 1'b0;
        end
        else if (!st.done)
        begin
            next_st.count = st.count + 1'b1;
            next_st.done = next_st.count[SEL_BIT];
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign done = st.done;
endmodule : rss_stab_timer

// ===== sim/rss_pin_model.sv
// external reset circuit model: pulls the open-drain reset pin low on command
// assumes the bench resolves the pin level from this pull and the device enable
`timescale 1ns/1ps
module rss_pin_model
(
    input wire logic clk,
    input wire logic start,
    input wire logic [7:0] hold_cycles,
    output logic pull_low
);
    logic [7:0] remain;

    // holds pin low
    // reloads while start is high, so a start held through power-up covers it
    always_ff @(posedge clk)
    begin
        if (start)
            remain <= hold_cycles;
        else if (remain != 8'h00)
            remain <= remain - 8'h01;
    end

    // released pin floats back to the pull-up level, never a stale value
    assign pull_low = start || (remain != 8'h00);
endmodule : rss_pin_model

// ===== sim/tb_top.sv
// self-checking bench for the reset source sequencer
// assumes a shortened timebase and a pulled-up open-drain reset pin
`timescale 1ns/1ps
module tb_top;
    localparam int SEL = 4;
    localparam int STAB_CYC = 1 << SEL;
    typedef struct {logic [15:0] pc; logic [15:0] oe;} rss_note_type;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pin_start = 1'b1;
    logic [7:0] pin_hold = 8'h1E;
    logic soft_reset_write = 1'b0, soft_reset_bit = 1'b1, watchdog_overflow = 1'b0;
    logic stop_mode = 1'b0, io_config_write = 1'b0;
    logic [7:0] rom_data = 8'h00;
    logic pull_low, rst_pin_n, rst_pin_out, rst_pin_oe, rom_rd, internal_reset, cpu_run;
    logic io_hiz, ram_clear_req, ram_write_block, run_q;
    logic [15:0] rom_addr, start_pc, vec;
    logic [7:0] mode_byte;
    logic [15:0] fetch_addr [3] = '{rss_pkg::MODE_ADDR, rss_pkg::VEC_HI_ADDR,
        rss_pkg::VEC_LO_ADDR};
    rss_note_type notes [$];
    rss_note_type note;
    int miscompares = 0, cmp_count = 0, fidx = 0, oe_cnt = 0, seed = 10080;

    initial forever #4 clk = ~clk;

    // open-drain pin: low when either party pulls, else the pull-up wins
    assign rst_pin_n = !(pull_low || (rst_pin_oe && !rst_pin_out));

    rss_pin_model rss_pin_model_i (.clk(clk), .start(pin_start), .hold_cycles(pin_hold),
        .pull_low(pull_low));

    rss_reset_sequencer #(.TBT_WIDTH(5), .TBT_SEL_BIT(SEL)) rss_reset_sequencer_i (
        .clk(clk), .sys_rst(sys_rst), .rst_pin_n_in(rst_pin_n), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe), .soft_reset_write(soft_reset_write),
        .soft_reset_bit(soft_reset_bit), .watchdog_overflow(watchdog_overflow),
        .stop_mode(stop_mode), .io_config_write(io_config_write), .rom_data(rom_data),
        .rom_addr(rom_addr), .rom_rd(rom_rd), .internal_reset(internal_reset),
        .cpu_run(cpu_run), .start_pc(start_pc), .mode_byte(mode_byte), .io_hiz(io_hiz),
        .ram_clear_req(ram_clear_req), .ram_write_block(ram_write_block));

    function automatic logic [7:0] rom_byte(input logic [15:0] a);
        if (a == rss_pkg::MODE_ADDR)
            return rss_pkg::MODE_SINGLE_CHIP;
        return (a == rss_pkg::VEC_HI_ADDR) ? vec[15:8] : vec[7:0];
    endfunction : rom_byte

    // rom answers one cycle after a read; otherwise the bus toggles so stale data shows
    always @(posedge clk)
        rom_data <= rom_rd ? rom_byte(rom_addr) : ~rom_data;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // bounded wait for internal reset to reach a level
    task automatic wait_level(input logic v);
        int n;
        n = 0;
        while (internal_reset !== v && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 400)
        begin
            miscompares++;
            close_out();
        end
    endtask : wait_level

    // monitor: fetch order on every read, full compare at each wake-up
    always @(posedge clk)
    begin
        run_q <= cpu_run;
        if (rom_rd === 1'b1)
        begin
            check("rom_addr", {16'h0000, rom_addr}, {16'h0000, fetch_addr[fidx % 3]});
            fidx++;
        end
        if (rst_pin_oe === 1'b1)
            oe_cnt++;
        if (cpu_run === 1'b1 && run_q !== 1'b1)
        begin
            if (notes.size() == 0)
                check("wake", 32'h0, 32'h1);
            else
            begin
                note = notes.pop_front();
                check("start_pc", {16'h0, start_pc}, {16'h0, note.pc});
                check("oe_cycles", 32'(oe_cnt), {16'h0, note.oe});
                check("mode_byte", 32'(mode_byte), 32'(rss_pkg::MODE_SINGLE_CHIP));
                check("fetch_count", 32'(fidx), 32'h3);
                check("io_hiz", {31'h0, io_hiz}, 32'h1);
                check("ram_clear_req", {31'h0, ram_clear_req}, 32'h0);
                check("rst_pin_out", {31'h0, rst_pin_out}, 32'h0);
            end
            fidx = 0;
            oe_cnt = 0;
        end
    end

    initial
    begin
        vec = 16'($random(seed));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        pin_start <= 1'b0;
        notes.push_back('{vec, 16'(STAB_CYC)});
        repeat (3) @(posedge clk);
        #1;
        check("por_hold", {internal_reset, io_hiz, ram_clear_req}, 32'h7);
        wait_level(1'b0);
        repeat (3) @(posedge clk);
        // software write of one must not reset
        soft_reset_write <= 1'b1;
        @(posedge clk);
        soft_reset_write <= 1'b0;
        repeat (20) @(posedge clk);
        check("cpu_run", {31'h0, cpu_run}, 32'h1);
        for (int k = 0; k < 8; k++)
        begin
            vec = 16'($random(seed));
            @(posedge clk);
            soft_reset_bit <= 1'b0;
            soft_reset_write <= (k % 4 == 0);
            watchdog_overflow <= (k % 4 == 1);
            pin_start <= (k % 4 >= 2);
            stop_mode <= (k % 4 == 3);
            // last stop-mode reset outlasts the delay
            pin_hold <= (k == 7) ? 8'h20 : 8'(3 + ($random(seed) & 7));
            notes.push_back('{vec, (k % 4 < 2) ? 16'(rss_pkg::SHORT_RESET_CYC)
                : (k % 4 == 2) ? 16'h0 : 16'(STAB_CYC)});
            @(posedge clk);
            soft_reset_write <= 1'b0;
            watchdog_overflow <= 1'b0;
            pin_start <= 1'b0;
            wait_level(1'b1);
            stop_mode <= 1'b0;
            // a second watchdog inside the short reset is ignored
            if (k % 4 == 1)
                watchdog_overflow <= 1'b1;
            #1;
            if (k % 4 >= 2)
                check("ram_write_block", {31'h0, ram_write_block}, 32'h1);
            @(posedge clk);
            watchdog_overflow <= 1'b0;
            wait_level(1'b0);
            repeat (3) @(posedge clk);
        end
        io_config_write <= 1'b1;
        @(posedge clk);
        io_config_write <= 1'b0;
        repeat (2) @(posedge clk);
        check("io_hiz", {31'h0, io_hiz}, 32'h0);
        check("notes_left", 32'(notes.size()), 32'h0);
        close_out();
    end
endmodule : tb_top
